// file: include/isp_pkg.sv
// Contract
// - Programmer waits at least 20 ms after reset low before the enable.
// - Programmer always shifts all four enable bytes, echo right or wrong.
// - Missing echo: pulse reset high, then issue a fresh enable instruction.
// - Clock low and high each over 2 CPU cycles, 3 at 12 MHz up.
// - Without a low clock at power-up, clock low then reset pulse.
// - Page buffer filled bytewise by low 5 address bits, low first.
// - Without polling, wait 4.5 ms after a page write.
// - EEPROM written bytewise; without polling, wait 9.0 ms per byte.
// - While a write is in progress, only polling reads are issued.
// - Polling a page value of 0xFF is useless; use the fixed wait.
// - EEPROM bytes of 0xFF cannot be polled; use the fixed wait.
// - Session ends by releasing reset high.
// - Enable instruction must run before any program or erase instruction.
package isp_pkg;
    localparam int unsigned CLK_HZ = 125_000_000;
    localparam real POWERUP_WAIT_MS = 20.0;
    localparam real PAGE_WRITE_WAIT_MS = 4.5;
    localparam real EEPROM_BYTE_WAIT_MS = 9.0;
    localparam real ERASE_WAIT_MS = 9.0;
    localparam real MS_PER_S = 1000.0;
    localparam int unsigned CPU_FAST_HZ = 12_000_000;
    localparam int unsigned SCK_CPU_SLOW = 2;
    localparam int unsigned SCK_CPU_FAST = 3;
    localparam int unsigned RST_PULSE_CPU = 2;
    localparam int unsigned ADDR_W = 12;
    localparam int unsigned PAGE_OFS_W = 5;
    localparam int unsigned EE_ADDR_HI = 8;
    localparam int unsigned INSTR_BITS = 32;
    localparam int unsigned RSP_W = 9;
    localparam logic [7:0] OPC_ENABLE = 8'hac;
    localparam logic [7:0] ECHO_BYTE = 8'h53;
    localparam logic [7:0] ERASE_ARG = 8'h80;
    localparam logic [7:0] OPC_LOAD = 8'h40;
    localparam logic [7:0] OPC_PAGE_WR = 8'h4c;
    localparam logic [7:0] OPC_READ_PROG = 8'h20;
    localparam logic [7:0] OPC_READ_EE = 8'ha0;
    localparam logic [7:0] OPC_WRITE_EE = 8'hc0;
    localparam logic [7:0] HIGH_SEL = 8'h08;
    localparam logic [7:0] ERASED = 8'hff;

    typedef enum logic [3:0] {
        OP_ENABLE, OP_ERASE, OP_LOAD_LO, OP_LOAD_HI, OP_WRITE_PAGE,
        OP_READ_LO, OP_READ_HI, OP_READ_EE, OP_WRITE_EE, OP_END
    } op_e;
endpackage : isp_pkg

// file: include/isp_link_if.sv
`timescale 1ns/10ps
interface isp_link_if;
    logic start;
    logic [isp_pkg::INSTR_BITS-1:0] instr;
    logic busy;
    logic done;
    logic [isp_pkg::INSTR_BITS-1:0] rx;
    modport ctl (output start, output instr, input busy, input done,
        input rx);
    modport eng (input start, input instr, output busy, output done,
        output rx);
endinterface : isp_link_if

// file: verilog/isp_shift_engine.sv
`timescale 1ns/10ps
module isp_shift_engine
    import isp_pkg::*;
#(
    parameter int unsigned HALF_CYC = 4
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic reset_n,
    // Controller side
    isp_link_if.eng link,
    // Device pins
    input wire logic miso_pin,
    output logic sck_q,
    output logic mosi_q
);
    localparam int unsigned CW = $clog2(HALF_CYC + 1);

    logic miso_m_q;
    logic miso_s_q;
    logic busy_q;
    logic done_q;
    logic [CW-1:0] cnt_q;
    logic [4:0] bit_q;
    logic [INSTR_BITS-1:0] tx_q;
    logic [INSTR_BITS-1:0] rx_q;
    logic half_end;

    assign half_end = (cnt_q == CW'(HALF_CYC - 1));
    assign link.busy = busy_q;
    assign link.done = done_q;
    assign link.rx = rx_q;

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            miso_m_q <= 1'b0;
            miso_s_q <= 1'b0;
        end else begin
            miso_m_q <= miso_pin;
            miso_s_q <= miso_m_q;
        end
    end

    // HALF_CYC must exceed the two-stage MISO delay for a clean sample
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            busy_q <= 1'b0;
            done_q <= 1'b0;
            sck_q <= 1'b0;
            mosi_q <= 1'b0;
            cnt_q <= '0;
            bit_q <= '0;
            tx_q <= '0;
            rx_q <= '0;
        end else begin
            done_q <= 1'b0;
            if (!busy_q) begin
                cnt_q <= '0;
                if (link.start) begin
                    busy_q <= 1'b1;
                    bit_q <= '0;
                    mosi_q <= link.instr[INSTR_BITS-1];
                    tx_q <= {link.instr[INSTR_BITS-2:0], 1'b0};
                end
            end else if (!half_end) begin
                cnt_q <= cnt_q + 1'b1;
            end else begin
                cnt_q <= '0;
                sck_q <= !sck_q;
                if (!sck_q) begin
                    // Device drove this bit at the previous falling edge
                    rx_q <= {rx_q[INSTR_BITS-2:0], miso_s_q};
                end else if (bit_q == 5'd31) begin
                    busy_q <= 1'b0;
                    done_q <= 1'b1;
                    mosi_q <= 1'b0;
                end else begin
                    // Data changes while clock is low, stable at rise
                    bit_q <= bit_q + 1'b1;
                    mosi_q <= tx_q[INSTR_BITS-1];
                    tx_q <= {tx_q[INSTR_BITS-2:0], 1'b0};
                end
            end
        end
    end

    logic sck_prev_q;
    logic [CW-1:0] lvl_cnt_q;
    logic [5:0] rise_cnt_q;

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            sck_prev_q <= 1'b0;
            lvl_cnt_q <= '0;
            rise_cnt_q <= '0;
        end else begin
            sck_prev_q <= sck_q;
            if (sck_q != sck_prev_q) begin
                lvl_cnt_q <= CW'(1);
            end else if (lvl_cnt_q != CW'(HALF_CYC)) begin
                lvl_cnt_q <= lvl_cnt_q + 1'b1;
            end
            if (link.start && !busy_q) begin
                rise_cnt_q <= '0;
            end else if (sck_q && !sck_prev_q) begin
                rise_cnt_q <= rise_cnt_q + 1'b1;
            end
        end
    end

    a_sck_phase_min: assert property (@(posedge ref_clk) disable iff (!reset_n)
        (sck_q != sck_prev_q) |-> lvl_cnt_q >= CW'(HALF_CYC))
        else $error("serial clock phase shorter than minimum");

    a_four_bytes: assert property (@(posedge ref_clk) disable iff (!reset_n)
        done_q |-> rise_cnt_q == 6'd32 && !sck_q)
        else $error("instruction ended before 32 clock pulses");
endmodule : isp_shift_engine

// file: verilog/isp_rsp_buffer.sv
`timescale 1ns/10ps
module isp_rsp_buffer #(
    parameter int unsigned WIDTH = 9,
    parameter int unsigned DEPTH = 2
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic reset_n,
    // Fill side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // Drain side
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    // Shift structure keeps the head in a flop for a registered output
    logic vld_q [DEPTH];
    logic [WIDTH-1:0] mem_q [DEPTH];
    logic after_v [DEPTH];
    logic [WIDTH-1:0] after_d [DEPTH];
    logic push;
    logic pop;

    assign in_ready = !vld_q[DEPTH-1];
    assign push = in_valid && in_ready;
    assign pop = vld_q[0] && out_ready;
    assign out_valid = vld_q[0];
    assign out_data = mem_q[0];

    for (genvar i = 0; i < DEPTH; i++) begin : g_ent
        logic load;
        if (i == DEPTH - 1) begin : g_last
            assign after_v[i] = pop ? 1'b0 : vld_q[i];
            assign after_d[i] = mem_q[i];
        end else begin : g_mid
            assign after_v[i] = pop ? vld_q[i+1] : vld_q[i];
            assign after_d[i] = pop ? mem_q[i+1] : mem_q[i];
        end
        if (i == 0) begin : g_head
            assign load = push && !after_v[i];
        end else begin : g_tail
            assign load = push && !after_v[i] && after_v[i-1];
        end
        always_ff @(posedge ref_clk or negedge reset_n) begin
            if (!reset_n) begin
                vld_q[i] <= 1'b0;
                mem_q[i] <= '0;
            end else begin
                vld_q[i] <= after_v[i] || load;
                mem_q[i] <= load ? in_data : after_d[i];
            end
        end
    end
endmodule : isp_rsp_buffer

// file: verilog/isp_programmer.sv
`timescale 1ns/10ps
module isp_programmer
    import isp_pkg::*;
#(
    parameter int unsigned CPU_HZ = 8_000_000,
    parameter int unsigned MAX_TRIES = 4,
    parameter int unsigned POWERUP_WAIT_CYC =
        int'($ceil(POWERUP_WAIT_MS * CLK_HZ / MS_PER_S)),
    parameter int unsigned PAGE_WAIT_CYC =
        int'($ceil(PAGE_WRITE_WAIT_MS * CLK_HZ / MS_PER_S)),
    parameter int unsigned EE_WAIT_CYC =
        int'($ceil(EEPROM_BYTE_WAIT_MS * CLK_HZ / MS_PER_S)),
    parameter int unsigned ERASE_WAIT_CYC =
        int'($ceil(ERASE_WAIT_MS * CLK_HZ / MS_PER_S))
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic reset_n,
    // Command
    input wire logic cmd_valid,
    output logic cmd_ready,
    input wire op_e cmd_op,
    input wire logic [ADDR_W-1:0] cmd_addr,
    input wire logic [7:0] cmd_data,
    input wire logic cmd_poll,
    // Response
    output logic rsp_valid,
    input wire logic rsp_ready,
    output logic [7:0] rsp_data,
    output logic rsp_err,
    // Status
    output logic session_active,
    // Device pins
    output logic isp_reset_n,
    output logic isp_sck,
    output logic isp_mosi,
    input wire logic isp_miso
);
    localparam longint unsigned SCK_CPU =
        (CPU_HZ >= CPU_FAST_HZ) ? SCK_CPU_FAST : SCK_CPU_SLOW;
    // One CPU cycle extra because the phase must be strictly longer
    localparam int unsigned SCK_HALF_CYC =
        int'(((SCK_CPU + 1) * CLK_HZ + CPU_HZ - 1) / CPU_HZ);
    localparam int unsigned RST_PULSE_CYC = int'((longint'(RST_PULSE_CPU)
        * CLK_HZ + CPU_HZ - 1) / CPU_HZ);
    localparam int unsigned TW = $clog2(MAX_TRIES + 1);

    typedef enum logic [2:0] {
        ST_IDLE, ST_PULSE, ST_SETTLE, ST_SHIFT, ST_WAIT, ST_RESP
    } state_e;

    isp_link_if link ();

    state_e state_q;
    op_e op_q;
    logic [ADDR_W-1:0] addr_q;
    logic [7:0] data_q;
    logic poll_q;
    logic [31:0] wait_q;
    logic [TW-1:0] tries_q;
    logic session_q;
    logic rst_pin_q;
    logic ready_q;
    logic start_q;
    logic [INSTR_BITS-1:0] instr_q;
    logic [RSP_W-1:0] rsp_q;
    logic lo_valid_q;
    logic [PAGE_OFS_W-1:0] lo_addr_q;
    logic accept;
    logic lo_ok;
    logic echo_ok;
    logic poll_hit;
    logic [31:0] wait_need;
    logic buf_ready;

    function automatic logic [INSTR_BITS-1:0] build_instr(
        input op_e op, input logic [ADDR_W-1:0] a, input logic [7:0] d);
        logic [INSTR_BITS-1:0] w;
        w = '0;
        unique case (op)
            OP_ENABLE: w = {OPC_ENABLE, ECHO_BYTE, 16'h0000};
            OP_ERASE: w = {OPC_ENABLE, ERASE_ARG, 16'h0000};
            OP_LOAD_LO: w = {OPC_LOAD, 11'h000, a[PAGE_OFS_W-1:0], d};
            OP_LOAD_HI: w = {OPC_LOAD | HIGH_SEL, 11'h000,
                a[PAGE_OFS_W-1:0], d};
            OP_WRITE_PAGE: w = {OPC_PAGE_WR, 4'h0, a[ADDR_W-1:8],
                a[7:PAGE_OFS_W], 13'h0000};
            OP_READ_LO: w = {OPC_READ_PROG, 4'h0, a, 8'h00};
            OP_READ_HI: w = {OPC_READ_PROG | HIGH_SEL, 4'h0, a, 8'h00};
            OP_READ_EE: w = {OPC_READ_EE, 7'h00, a[EE_ADDR_HI:0], 8'h00};
            OP_WRITE_EE: w = {OPC_WRITE_EE, 7'h00, a[EE_ADDR_HI:0], d};
            OP_END: w = '0;
        endcase
        return w;
    endfunction : build_instr

    assign accept = cmd_valid && ready_q;
    assign lo_ok = lo_valid_q && (lo_addr_q == cmd_addr[PAGE_OFS_W-1:0]);
    assign echo_ok = (link.rx[15:8] == ECHO_BYTE);
    // Only a polling read in the wait state may end a write early
    assign poll_hit = poll_q && state_q == ST_WAIT && link.done
        && (link.rx[7:0] == data_q);
    assign link.start = start_q;
    assign link.instr = instr_q;

    always_comb begin
        unique case (op_q)
            OP_ERASE: wait_need = ERASE_WAIT_CYC;
            OP_WRITE_PAGE: wait_need = PAGE_WAIT_CYC;
            OP_WRITE_EE: wait_need = EE_WAIT_CYC;
            default: wait_need = '0;
        endcase
    end

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            state_q <= ST_IDLE;
            op_q <= OP_END;
            addr_q <= '0;
            data_q <= '0;
            poll_q <= 1'b0;
            wait_q <= '0;
            tries_q <= '0;
            session_q <= 1'b0;
            rst_pin_q <= 1'b1;
            ready_q <= 1'b0;
            start_q <= 1'b0;
            instr_q <= '0;
            rsp_q <= '0;
        end else begin
            start_q <= 1'b0;
            unique case (state_q)
                ST_IDLE: begin
                    ready_q <= 1'b1;
                    if (accept) begin
                        ready_q <= 1'b0;
                        op_q <= cmd_op;
                        addr_q <= cmd_addr;
                        data_q <= cmd_data;
                        // A 0xFF value cannot be told apart from busy
                        poll_q <= cmd_poll && (cmd_data != ERASED)
                            && (cmd_op != OP_ERASE);
                        rsp_q <= {1'b1, 8'h00};
                        if (cmd_op == OP_ENABLE) begin
                            tries_q <= '0;
                            session_q <= 1'b0;
                            rst_pin_q <= 1'b1;
                            wait_q <= RST_PULSE_CYC;
                            state_q <= ST_PULSE;
                        end else if (cmd_op == OP_END) begin
                            rst_pin_q <= 1'b1;
                            session_q <= 1'b0;
                            rsp_q <= '0;
                            state_q <= ST_RESP;
                        end else if (!session_q) begin
                            state_q <= ST_RESP;
                        end else if (cmd_op == OP_LOAD_HI && !lo_ok) begin
                            state_q <= ST_RESP;
                        end else begin
                            instr_q <= build_instr(cmd_op, cmd_addr,
                                cmd_data);
                            start_q <= 1'b1;
                            state_q <= ST_SHIFT;
                        end
                    end
                end
                ST_PULSE: begin
                    if (wait_q == '0) begin
                        rst_pin_q <= 1'b0;
                        wait_q <= POWERUP_WAIT_CYC;
                        state_q <= ST_SETTLE;
                    end else begin
                        wait_q <= wait_q - 1'b1;
                    end
                end
                ST_SETTLE: begin
                    if (wait_q == '0) begin
                        instr_q <= build_instr(OP_ENABLE, '0, '0);
                        start_q <= 1'b1;
                        state_q <= ST_SHIFT;
                    end else begin
                        wait_q <= wait_q - 1'b1;
                    end
                end
                ST_SHIFT: begin
                    if (link.done) begin
                        rsp_q <= {1'b0, link.rx[7:0]};
                        wait_q <= wait_need;
                        if (op_q != OP_ENABLE) begin
                            state_q <= (wait_need == '0) ? ST_RESP : ST_WAIT;
                        end else if (echo_ok) begin
                            session_q <= 1'b1;
                            state_q <= ST_RESP;
                        end else if (tries_q < TW'(MAX_TRIES - 1)) begin
                            tries_q <= tries_q + 1'b1;
                            rst_pin_q <= 1'b1;
                            wait_q <= RST_PULSE_CYC;
                            state_q <= ST_PULSE;
                        end else begin
                            rsp_q <= {1'b1, link.rx[15:8]};
                            state_q <= ST_RESP;
                        end
                    end
                end
                ST_WAIT: begin
                    // Only read-backs may reach the device until done
                    if (wait_q != '0) begin
                        wait_q <= wait_q - 1'b1;
                    end
                    if (poll_hit) begin
                        wait_q <= '0;
                    end
                    if (!link.busy && !start_q && !link.done) begin
                        if (wait_q == '0) begin
                            state_q <= ST_RESP;
                        end else if (poll_q) begin
                            instr_q <= build_instr((op_q == OP_WRITE_EE)
                                ? OP_READ_EE : OP_READ_LO, addr_q, '0);
                            start_q <= 1'b1;
                        end
                    end
                end
                ST_RESP: begin
                    if (buf_ready) begin
                        state_q <= ST_IDLE;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            lo_valid_q <= 1'b0;
            lo_addr_q <= '0;
        end else if (accept && cmd_op == OP_LOAD_LO) begin
            lo_valid_q <= session_q;
            lo_addr_q <= cmd_addr[PAGE_OFS_W-1:0];
        end else if ((accept && cmd_op != OP_LOAD_HI)
            || (state_q == ST_SHIFT && link.done && op_q == OP_LOAD_HI)) begin
            lo_valid_q <= 1'b0;
        end
    end

    isp_shift_engine #(
        .HALF_CYC(SCK_HALF_CYC)
    ) u_engine (
        .ref_clk(ref_clk),
        .reset_n(reset_n),
        .link(link.eng),
        .miso_pin(isp_miso),
        .sck_q(isp_sck),
        .mosi_q(isp_mosi)
    );

    // A stalled reader backs up into ST_RESP and so blocks new commands
    isp_rsp_buffer #(
        .WIDTH(RSP_W),
        .DEPTH(2)
    ) u_rsp (
        .ref_clk(ref_clk),
        .reset_n(reset_n),
        .in_valid(state_q == ST_RESP),
        .in_ready(buf_ready),
        .in_data(rsp_q),
        .out_valid(rsp_valid),
        .out_ready(rsp_ready),
        .out_data({rsp_err, rsp_data})
    );

    assign cmd_ready = ready_q;
    assign session_active = session_q;
    assign isp_reset_n = rst_pin_q;

    logic [31:0] since_low_q;
    logic [15:0] hi_cnt_q;
    logic [31:0] quiet_q;
    logic [31:0] need_q;

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            since_low_q <= '0;
            hi_cnt_q <= '0;
            quiet_q <= '1;
            need_q <= '0;
        end else begin
            since_low_q <= rst_pin_q ? '0 : (since_low_q == '1 ? since_low_q
                : since_low_q + 1'b1);
            hi_cnt_q <= !rst_pin_q ? '0 : (hi_cnt_q == '1 ? hi_cnt_q
                : hi_cnt_q + 1'b1);
            if (state_q == ST_SHIFT && link.done) begin
                quiet_q <= '0;
                need_q <= wait_need;
            end else if (quiet_q != '1) begin
                quiet_q <= quiet_q + 1'b1;
            end
            if (poll_hit) begin
                need_q <= '0;
            end
        end
    end

    a_powerup_wait: assert property (@(posedge ref_clk) disable iff (!reset_n)
        start_q && instr_q[31:16] == {OPC_ENABLE, ECHO_BYTE}
        |-> since_low_q >= POWERUP_WAIT_CYC)
        else $error("enable sent too soon after reset low");
    a_enable_first: assert property (@(posedge ref_clk) disable iff (!reset_n)
        start_q && instr_q[31:16] != {OPC_ENABLE, ECHO_BYTE}
        |-> session_q && !rst_pin_q)
        else $error("instruction sent outside a session");
    a_resync_pulse: assert property (@(posedge ref_clk) disable iff (!reset_n)
        state_q == ST_SHIFT && link.done && op_q == OP_ENABLE && !echo_ok
        && tries_q < TW'(MAX_TRIES - 1) |=> rst_pin_q ##1 rst_pin_q)
        else $error("no reset pulse after lost echo");
    a_pulse_sck_low: assert property (@(posedge ref_clk) disable iff (!reset_n)
        $rose(rst_pin_q) |-> !isp_sck [*3])
        else $error("serial clock not low around reset pulse");
    a_pulse_width: assert property (@(posedge ref_clk) disable iff (!reset_n)
        $fell(rst_pin_q) |-> hi_cnt_q >= 16'(RST_PULSE_CYC))
        else $error("reset pulse too short");
    a_write_wait: assert property (@(posedge ref_clk) disable iff (!reset_n)
        start_q && state_q != ST_WAIT |-> quiet_q >= need_q)
        else $error("instruction sent during write wait");
    a_lo_before_hi: assert property (@(posedge ref_clk) disable iff (!reset_n)
        start_q && instr_q[31:24] == (OPC_LOAD | HIGH_SEL)
        |-> lo_valid_q && lo_addr_q == instr_q[8+PAGE_OFS_W-1:8])
        else $error("high byte loaded before low byte");
    a_release_end: assert property (@(posedge ref_clk) disable iff (!reset_n)
        accept && cmd_op == OP_END |=> rst_pin_q && !session_q)
        else $error("reset not released at session end");
endmodule : isp_programmer

// file: tb/isp_device_model.sv
`timescale 1ns/10ps
module isp_device_model (
    // Device pins
    input wire logic rst_n,
    input wire logic sck,
    input wire logic mosi,
    output logic miso
);
    logic [31:0] sh;
    logic [7:0] n, tx, pm [0:8191], pb [0:63], ee [0:511];
    logic en, m;
    int i;
    realtime busy_t = 0.0;
    // Released line shows the inverse so a stale bit cannot pass
    assign miso = rst_n ? ~m : m;
    always @(negedge sck) if (!rst_n) m <= tx[~n[2:0]];
    always @(posedge sck or posedge rst_n) begin
        if (rst_n) begin
            n = 8'h00;
            en = 1'b0;
        end else begin
            sh = {sh[30:0], mosi};
            n = n + 8'h01;
            if (n[2:0] == 3'h0) tx = sh[7:0];
            if (n == 8'h18 && sh[23:16] ==? 8'b0010?000)
                tx = ($realtime < busy_t) ? 8'hff
                    : pm[{sh[11:0], sh[19]}];
            if (n == 8'h18 && sh[23:16] == 8'ha0)
                tx = ($realtime < busy_t) ? 8'hff : ee[sh[8:0]];
            if (n == 8'h20) begin
                n = 8'h00;
                if (sh[31:16] == 16'hac53) en = 1'b1;
                if (en && sh[31:21] == 11'b10101100100)
                    for (i = 0; i < 8192; i++) begin
                        pm[i] = 8'hff;
                        ee[i[8:0]] = 8'hff;
                    end
                if (en && sh[31:24] ==? 8'b0100?000)
                    pb[{sh[12:8], sh[27]}] = sh[7:0];
                if (en && sh[31:24] == 8'h4c)
                    for (i = 0; i < 64; i++) pm[{sh[19:13], i[5:0]}] = pb[i];
                // Busy windows: the EEPROM one outlasts the first poll read, which sees 0xFF; the page one ends before a read selects its byte
                if (en && sh[31:24] == 8'h4c) busy_t = $realtime + 2000.0;
                if (en && sh[31:24] == 8'hc0) ee[sh[16:8]] = sh[7:0];
                if (en && sh[31:24] == 8'hc0) busy_t = $realtime + 8000.0;
            end
        end
    end
endmodule : isp_device_model

// file: tb/isp_programmer_tb.sv
`timescale 1ns/10ps
module isp_programmer_tb;
    import isp_pkg::*;
    logic ref_clk = 0, reset_n = 0, cmd_valid = 0, cmd_poll = 1;
    logic rsp_ready = 0, cmd_ready, rsp_valid, rsp_err, session_active;
    logic isp_reset_n, isp_sck, isp_mosi, isp_miso;
    op_e cmd_op = OP_END;
    logic [11:0] cmd_addr = 12'h000;
    logic [7:0] cmd_data = 8'h00, rsp_data;
    int miscompares = 0, cmp_count = 0;
    isp_programmer #(.CPU_HZ(40_000_000), .POWERUP_WAIT_CYC(50),
        .PAGE_WAIT_CYC(40), .EE_WAIT_CYC(60), .ERASE_WAIT_CYC(60)) i_dut (.*);
    isp_device_model i_dev (.rst_n(isp_reset_n), .sck(isp_sck),
        .mosi(isp_mosi), .miso(isp_miso));
    initial forever #4 ref_clk = ~ref_clk;
    task automatic check(input logic [8:0] seen, input logic [8:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            miscompares++;
            $display("[ERR] %0t seen %h exp %h", $time, seen, exp);
        end
    endtask : check
    // Bit 9 of e asks for the data byte to be compared too
    task automatic run(input op_e op, input logic [11:0] a,
        input logic [7:0] d, input logic [9:0] e);
        cmd_op <= op;
        cmd_addr <= a;
        cmd_data <= d;
        cmd_valid <= 1'b1;
        do @(posedge ref_clk); while (cmd_ready !== 1'b1);
        cmd_valid <= 1'b0;
        // Consumer stalls so the response must stand in the buffer
        repeat (9) @(posedge ref_clk);
        while (rsp_valid !== 1'b1) @(posedge ref_clk);
        check({rsp_err, e[9] ? rsp_data : 8'h00}, e[8:0]);
        rsp_ready <= 1'b1;
        @(posedge ref_clk);
        rsp_ready <= 1'b0;
        @(posedge ref_clk);
    endtask : run
    task automatic t_refuse();
        run(OP_READ_EE, 12'h005, 8'h00, 10'h300);
    endtask : t_refuse
    task automatic t_enable();
        run(OP_ENABLE, 12'h000, 8'h00, 10'h000);
        check({8'h00, session_active}, 9'h001);
    endtask : t_enable
    task automatic t_eeprom();
        run(OP_ERASE, 12'h000, 8'h00, 10'h000);
        run(OP_READ_EE, 12'h005, 8'h00, 10'h2ff);
        run(OP_WRITE_EE, 12'h005, 8'h3c, 10'h000);
        run(OP_READ_EE, 12'h005, 8'h00, 10'h23c);
    endtask : t_eeprom
    task automatic t_page();
        run(OP_LOAD_LO, 12'h021, 8'ha5, 10'h000);
        run(OP_LOAD_HI, 12'h021, 8'h5a, 10'h000);
        run(OP_LOAD_HI, 12'h022, 8'h11, 10'h300);
        run(OP_WRITE_PAGE, 12'h020, 8'hff, 10'h000);
        run(OP_READ_LO, 12'h021, 8'h00, 10'h2a5);
        run(OP_READ_HI, 12'h021, 8'h00, 10'h25a);
    endtask : t_page
    task automatic t_end();
        run(OP_END, 12'h000, 8'h00, 10'h000);
        check({8'h00, isp_reset_n}, 9'h001);
        check({8'h00, session_active}, 9'h000);
        run(OP_READ_EE, 12'h005, 8'h00, 10'h300);
    endtask : t_end
    task automatic results();
        $display("compares %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : results
    initial begin
        repeat (5) @(posedge ref_clk);
        reset_n <= 1'b1;
        repeat (2) @(posedge ref_clk);
        t_refuse();
        t_enable();
        t_eeprom();
        t_page();
        t_end();
        results();
    end
    initial begin
        repeat (60000) @(posedge ref_clk);
        miscompares++;
        results();
    end
endmodule : isp_programmer_tb
